/* File: rtl/bwou_params.svh */
// Constants for the bit-manipulation word operation unit
`ifndef BWOU_PARAMS_SVH
`define BWOU_PARAMS_SVH
// ----------------------------------------
// Widths and field positions
// ----------------------------------------
`define BWOU_WORD_MSB 31
`define BWOU_BYTE_MSB 7
`define BWOU_HALF_MSB 15
`define BWOU_ROT_AMT_BITS 5
`define BWOU_BYTE_BITS 8
`define BWOU_NIB_BITS 4
`define BWOU_OP_BITS 5
`define BWOU_RESULT_RESET 'h0
`endif

/* File: rtl/bwou_pkg.sv */
// Types for the bit-manipulation word operation unit
`include "bwou_params.svh"
package bwou_pkg;
  // ----------------------------------------
  // Operation select codes
  // ----------------------------------------
  typedef enum logic [`BWOU_OP_BITS-1:0] {
    BWOU_OP_ROR_WORD_IMM = 5'h00,
    BWOU_OP_ROR_WORD_REG = 5'h01,
    BWOU_OP_SEXT_BYTE = 5'h02,
    BWOU_OP_SEXT_HALF = 5'h03,
    BWOU_OP_SHIFT1_ADD = 5'h04,
    BWOU_OP_SHIFT2_ADD = 5'h05,
    BWOU_OP_SHIFT3_ADD = 5'h06,
    BWOU_OP_SHIFT1_ADD_UW = 5'h07,
    BWOU_OP_SHIFT2_ADD_UW = 5'h08,
    BWOU_OP_SHIFT3_ADD_UW = 5'h09,
    BWOU_OP_SHIFT_LEFT_IMM_UNSIGNED_WORD = 5'h0A,
    BWOU_OP_DEINTERLEAVE = 5'h0B,
    BWOU_OP_INTERLEAVE = 5'h0C,
    BWOU_OP_XNOR = 5'h0D,
    BWOU_OP_BYTE_PERMUTE = 5'h0E,
    BWOU_OP_NIBBLE_PERMUTE = 5'h0F,
    BWOU_OP_ZEXT_HALF = 5'h10
  } bwou_op_t;
endpackage

/* File: rtl/bwou_unit.sv */
// Combinational result datapath for bit-manipulation word operations
`timescale 1ns/1ps
`include "bwou_params.svh"

module bwou_unit
  import bwou_pkg::*;
#(
  parameter int REG_WIDTH = 64
) (
  input wire logic [REG_WIDTH-1:0] first_source_in, // Operand one
  input wire logic [REG_WIDTH-1:0] second_source_in, // Operand two
  input wire logic [5:0] shift_imm_in, // Immediate shift count
  input wire logic [`BWOU_OP_BITS-1:0] op_select_in, // Operation code
  output logic [REG_WIDTH-1:0] result_out, // Destination value
  output logic op_illegal_out // High for unsupported select
);
  // ----------------------------------------
  // Local sizes
  // ----------------------------------------
  localparam int HALF = REG_WIDTH / 2; // Half register width
  localparam int NBYTES = REG_WIDTH / `BWOU_BYTE_BITS; // Byte elements
  localparam int NNIBS = REG_WIDTH / `BWOU_NIB_BITS; // Nibble elements
  localparam bit IS32 = (REG_WIDTH == 32); // Narrow configuration

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Rotate a word right, then sign-extend from its top bit
  function automatic logic [REG_WIDTH-1:0] ror_word_sext(
    input logic [REG_WIDTH-1:0] src,
    input logic [`BWOU_ROT_AMT_BITS-1:0] amt
  );
    logic [63:0] dbl;
    logic [31:0] rot;
    // Doubling the word turns the rotate into a plain shift
    dbl = {src[`BWOU_WORD_MSB:0], src[`BWOU_WORD_MSB:0]};
    // Low word of the shifted pair is the rotated word
    rot = 32'(dbl >> amt);
    // Surplus sign copies fall off when the cast trims to width
    return REG_WIDTH'({{(REG_WIDTH){rot[`BWOU_WORD_MSB]}}, rot});
  endfunction

  // Shift then add at full width; carry out is dropped by design
  function automatic logic [REG_WIDTH-1:0] shift_add(
    input logic [REG_WIDTH-1:0] idx,
    input logic [REG_WIDTH-1:0] base,
    input logic [1:0] amt
  );
    // Sum wraps at register width, as the register file would
    return REG_WIDTH'(base + (idx << amt));
  endfunction

  // Zero-extend the low word of a register
  function automatic logic [REG_WIDTH-1:0] zext_word(input logic [REG_WIDTH-1:0] src);
    return REG_WIDTH'(src[`BWOU_WORD_MSB:0]);
  endfunction

  // ----------------------------------------
  // Permute and interleave networks
  // ----------------------------------------
  logic [REG_WIDTH-1:0] byte_perm; // Byte lookup result
  logic [REG_WIDTH-1:0] nib_perm; // Nibble lookup result
  logic [REG_WIDTH-1:0] deint; // De-interleaved source
  logic [REG_WIDTH-1:0] inter; // Interleaved source

  // Byte lookup: index beyond element count yields zero
  always_comb begin
    logic [7:0] idx;
    idx = 8'h00;
    byte_perm = '0;
    for (int i = 0; i < NBYTES; i++) begin
      idx = second_source_in[i*8 +: 8];
      // Guard keeps the part-select inside the operand
      if (int'(idx) < NBYTES) begin
        byte_perm[i*8 +: 8] = first_source_in[int'(idx)*8 +: 8];
      end
    end
  end

  // Nibble lookup: same pattern at four-bit granule
  always_comb begin
    logic [3:0] idx;
    idx = 4'h0;
    nib_perm = '0;
    for (int i = 0; i < NNIBS; i++) begin
      idx = second_source_in[i*4 +: 4];
      // At full width every nibble index is in range
      if (int'(idx) < NNIBS) begin
        nib_perm[i*4 +: 4] = first_source_in[int'(idx)*4 +: 4];
      end
    end
  end

  // Bit scatter and gather; the two are exact inverses
  always_comb begin
    deint = '0;
    inter = '0;
    // One pass fills both networks; they share no state
    for (int i = 0; i < HALF; i++) begin
      deint[i] = first_source_in[2*i];
      deint[i+HALF] = first_source_in[2*i+1];
      inter[2*i] = first_source_in[i];
      inter[2*i+1] = first_source_in[i+HALF];
    end
  end

  // ----------------------------------------
  // Result select
  // ----------------------------------------
  // Pure logic, so the result follows the operands in the same cycle
  always_comb begin
    result_out = REG_WIDTH'(`BWOU_RESULT_RESET);
    op_illegal_out = 1'b0;
    // Defaults above mean every path drives both outputs
    case (op_select_in)
      // Word rotate by immediate count
      BWOU_OP_ROR_WORD_IMM: begin
        // Word rotate uses only the low five immediate bits
        result_out = ror_word_sext(first_source_in, shift_imm_in[4:0]);
      end
      // Count comes from operand two, low five bits
      BWOU_OP_ROR_WORD_REG: begin
        result_out = ror_word_sext(first_source_in, second_source_in[4:0]);
      end
      // Byte sign copy; cast trims the surplus copies
      BWOU_OP_SEXT_BYTE: begin
        result_out = REG_WIDTH'({{(REG_WIDTH){first_source_in[`BWOU_BYTE_MSB]}},
          first_source_in[`BWOU_BYTE_MSB:0]});
      end
      // Halfword sign copy to full width
      BWOU_OP_SEXT_HALF: begin
        result_out = REG_WIDTH'({{(REG_WIDTH){first_source_in[`BWOU_HALF_MSB]}},
          first_source_in[`BWOU_HALF_MSB:0]});
      end
      // Full-width scaled index plus base
      BWOU_OP_SHIFT1_ADD: begin
        result_out = shift_add(first_source_in, second_source_in, 2'd1);
      end
      // Index scaled by four
      BWOU_OP_SHIFT2_ADD: begin
        result_out = shift_add(first_source_in, second_source_in, 2'd2);
      end
      // Index scaled by eight
      BWOU_OP_SHIFT3_ADD: begin
        result_out = shift_add(first_source_in, second_source_in, 2'd3);
      end
      // Unsigned word index, so no sign smear upward
      BWOU_OP_SHIFT1_ADD_UW: begin
        result_out = shift_add(zext_word(first_source_in), second_source_in, 2'd1);
      end
      // Unsigned word index scaled by four
      BWOU_OP_SHIFT2_ADD_UW: begin
        result_out = shift_add(zext_word(first_source_in), second_source_in, 2'd2);
      end
      // Unsigned word index scaled by eight
      BWOU_OP_SHIFT3_ADD_UW: begin
        result_out = shift_add(zext_word(first_source_in), second_source_in, 2'd3);
      end
      // Zero-extend the word first, then shift left
      BWOU_OP_SHIFT_LEFT_IMM_UNSIGNED_WORD: begin
        // On a narrow register bit 5 of the count is meaningless; mask it
        if (IS32) begin
          result_out = zext_word(first_source_in) << shift_imm_in[4:0];
        end else begin
          result_out = zext_word(first_source_in) << shift_imm_in;
        end
      end
      // Even bits to the low half, odd bits to the high half
      BWOU_OP_DEINTERLEAVE: begin
        // Narrow configuration only; wide reports illegal, gives zero
        if (IS32) begin
          result_out = deint;
        end else begin
          op_illegal_out = 1'b1;
        end
      end
      // Halves merged into even and odd bits
      BWOU_OP_INTERLEAVE: begin
        if (IS32) begin
          result_out = inter;
        end else begin
          op_illegal_out = 1'b1;
        end
      end
      // Inverted exclusive OR over every bit
      BWOU_OP_XNOR: begin
        result_out = ~(first_source_in ^ second_source_in);
      end
      // Byte lookup network result
      BWOU_OP_BYTE_PERMUTE: begin
        result_out = byte_perm;
      end
      // Nibble lookup network result
      BWOU_OP_NIBBLE_PERMUTE: begin
        result_out = nib_perm;
      end
      // Low halfword kept, upper bits cleared
      BWOU_OP_ZEXT_HALF: begin
        // One select code serves both widths; decode maps both encodings here
        result_out = REG_WIDTH'(first_source_in[`BWOU_HALF_MSB:0]);
      end
      // Unused codes are refused, never a stale result
      default: begin
        op_illegal_out = 1'b1; // Unknown code gives zero
      end
    endcase
  end
endmodule

/* File: tb/bwou_decoder_model.sv */
// Decoder model that hands operation codes to the unit
`timescale 1ns/1ps
module bwou_decoder_model (
  input wire logic [5:0] form_in, // Instruction form, values arbitrary
  input wire logic [4:0] op_in, // Operation asked for otherwise
  output logic [4:0] op_out // Code to the unit
);
  // Narrow and wide zero-extend forms decode alike
  always_comb begin
    op_out = op_in;
    if (form_in == 6'h20 || form_in == 6'h21) begin
      op_out = 5'h10;
    end
  end
endmodule

/* File: tb/bwou_unit_props.sv */
// Assertion checker for the bit-manipulation word unit
`timescale 1ns/1ps
module bwou_unit_props
  import bwou_pkg::*;
#(parameter int REG_WIDTH = 64) (
  input wire logic [REG_WIDTH-1:0] first_source_in,
  input wire logic [REG_WIDTH-1:0] second_source_in,
  input wire logic [5:0] shift_imm_in,
  input wire logic [4:0] op_select_in,
  input wire logic [REG_WIDTH-1:0] result_out,
  input wire logic op_illegal_out
);
  // -----------------------------------
  // Private sample clock, unit is clockless
  // -----------------------------------
  logic chk_clk = 1'b0;
  always #5 chk_clk = ~chk_clk;
  default clocking @(posedge chk_clk); endclocking
  wire [4:0] op = op_select_in;
  wire [REG_WIDTH-1:0] a = first_source_in;
  wire [REG_WIDTH-1:0] b = second_source_in;
  wire [REG_WIDTH-1:0] r = result_out;
  // Expected rotated word; code 01 takes its count from operand two
  wire [31:0] rot = 32'({a[31:0], a[31:0]} >> (op[0] ? b[4:0] : shift_imm_in[4:0]));
  property p_rot; op < 5'h02 |-> r == REG_WIDTH'($signed(rot)); endproperty
  a_rot: assert property (p_rot) else $error("rotate wrong");
  property p_sextb; op == 5'h02 |-> r == REG_WIDTH'($signed(a[7:0])); endproperty
  a_sextb: assert property (p_sextb) else $error("sext byte wrong");
  property p_sexth; op == 5'h03 |-> r == REG_WIDTH'($signed(a[15:0])); endproperty
  a_sexth: assert property (p_sexth) else $error("sext half wrong");
  property p_sh; op inside {[5'h04:5'h06]} |-> r == b + (a << (op - 5'h03)); endproperty
  a_sh: assert property (p_sh) else $error("shift add wrong");
  property p_shuw;
    op inside {[5'h07:5'h09]} |-> r == b + (REG_WIDTH'(a[31:0]) << (op - 5'h06));
  endproperty
  a_shuw: assert property (p_shuw) else $error("word shift add wrong");
  property p_zexth; op == 5'h10 |-> r == REG_WIDTH'(a[15:0]); endproperty
  a_zexth: assert property (p_zexth) else $error("zext half wrong");
  property p_xnor; op == 5'h0D |-> r == ~(a ^ b); endproperty
  a_xnor: assert property (p_xnor) else $error("xnor wrong");
  // Interleave codes are refused at the wide width
  property p_ill;
    (op > 5'h10 || (REG_WIDTH == 64 && op inside {5'h0B, 5'h0C})) |-> op_illegal_out && r == '0;
  endproperty
  a_ill: assert property (p_ill) else $error("refusal wrong");
  c_perm8: cover property (op == 5'h0E);
  c_perm4: cover property (op == 5'h0F);
  c_ill: cover property (op_illegal_out);
endmodule
bind bwou_unit bwou_unit_props #(.REG_WIDTH(REG_WIDTH)) u_props (.*);

/* File: tb/tb.sv */
// Self-checking bench for the bit-manipulation word unit
`timescale 1ns/1ps
module tb;
  import bwou_pkg::*;
  logic clk_in = 1'b0;
  logic [4:0] op_req = 5'h00;
  logic [5:0] form = 6'h00;
  logic [4:0] op;
  logic [63:0] a = '0, b = '0;
  logic [5:0] imm = '0;
  logic [63:0] r;
  logic [31:0] r32;
  logic ill, ill32;
  int fails = 0, n_tests = 0;
  always #12.5 clk_in = ~clk_in;
  bwou_decoder_model dec (.form_in(form), .op_in(op_req), .op_out(op));
  bwou_unit dut (.first_source_in(a), .second_source_in(b), .shift_imm_in(imm),
    .op_select_in(op), .result_out(r), .op_illegal_out(ill));
  bwou_unit #(.REG_WIDTH(32)) dut32 (.first_source_in(a[31:0]), .second_source_in(b[31:0]),
    .shift_imm_in(imm), .op_select_in(op), .result_out(r32), .op_illegal_out(ill32));
  // Drive on the falling edge, result settles at once
  task automatic go(input logic [4:0] o, input logic [63:0] x, y, input logic [5:0] s);
    @(negedge clk_in);
    op_req = o;
    a = x;
    b = y;
    imm = s;
    #1;
  endtask
  task automatic chk(input string nm, input logic [63:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic t_rot;
    go(5'h00, 64'h1234_5678_8000_0001, 0, 6'h21);
    chk("rori", 64'hFFFF_FFFF_C000_0000, r);
    go(5'h01, 64'h3, 64'hFFE1, 0);
    chk("rorw", 64'hFFFF_FFFF_8000_0001, r);
    $display("done rot");
  endtask
  task automatic t_ext;
    go(5'h02, 64'h1234_5680, 0, 0);
    chk("sextb", 64'hFFFF_FFFF_FFFF_FF80, r);
    go(5'h03, 64'h1234_8000, 0, 0);
    chk("sexth", 64'hFFFF_FFFF_FFFF_8000, r);
    for (int f = 32; f < 34; f++) begin
      @(negedge clk_in);
      form = 6'(f);
      go(5'h00, 64'hFFFF_FFFF_FFFF_8001, 0, 0);
      chk("zexth", 64'h8001, r);
    end
    @(negedge clk_in);
    form = 6'h00;
    $display("done ext");
  endtask
  task automatic t_add;
    logic [63:0] x;
    x = 64'h8000_0001_8000_0001;
    for (int k = 1; k < 4; k++) begin
      go(5'(3 + k), x, 64'h5, 0);
      chk("shadd", (x << k) + 64'h5, r);
      go(5'(6 + k), x, 64'h5, 0);
      chk("shadduw", ({32'h0, x[31:0]} << k) + 64'h5, r);
    end
    go(5'h0A, x, 0, 6'h20);
    chk("slliuw", 64'h8000_0001_0000_0000, r);
    $display("done add");
  endtask
  task automatic t_perm;
    go(5'h0D, 64'hF0F0, 64'hFF00, 0);
    chk("xnor", 64'hFFFF_FFFF_FFFF_F00F, r);
    go(5'h0E, 64'h8877_6655_4433_2211, 64'h0800_0000_0000_0107, 0);
    chk("perm8", 64'h0011_1111_1111_2288, r);
    chk("perm8w", 64'h1111_2200, r32);
    go(5'h0F, 64'hFEDC_BA98_7654_3210, 64'h0123_4567_0000_00F7, 0);
    chk("perm4", 64'h0123_4567_0000_00F7, r);
    chk("perm4w", 64'h7, r32);
    $display("done perm");
  endtask
  task automatic t_zip;
    go(5'h0C, 64'hFFFF_0000, 0, 0);
    chk("zip", 64'hAAAA_AAAA, r32);
    chk("zipwide", 64'h1, ill);
    go(5'h0B, 64'hAAAA_AAAA, 0, 0);
    chk("unzip", 64'hFFFF_0000, r32);
    chk("unzipok", 0, ill32);
    go(5'h1F, 64'h1, 0, 0);
    chk("badcode", 0, r);
    chk("badill", 64'h1, ill);
    $display("done zip");
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    // No reset pin; the reset span simply elapses
    repeat (16) @(posedge clk_in);
    t_rot();
    t_ext();
    t_add();
    t_perm();
    t_zip();
    // Hold the last stimulus so the checker samples it
    @(negedge clk_in);
    summarize();
  end
endmodule
